// file: hw/conv_host_pkg.sv
// constants and carrier types for the host that runs the subranging converter
// assumes a 250 MHz clock_i and converter pins already synchronous to it
package conv_host_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int FAST_FALL_NS    = 30;   // fast grade longest high time
  localparam int SLOW_FALL_NS    = 50;   // slow grade longest high time
  localparam int SETTLE_NS       = 200;  // input settling before third flash
  // longest times round down
  localparam int FAST_HIGH_CYC   = (FAST_FALL_NS * 1000) / CLK_PERIOD_PS;
  localparam int SLOW_HIGH_CYC   = (SLOW_FALL_NS * 1000) / CLK_PERIOD_PS;
  localparam int SETTLE_CYC      = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int DAV_TIMEOUT_CYC = 1024; // give up waiting for data-valid

  // ---------------------------------------------------------------------------
  // result coding
  // ---------------------------------------------------------------------------
  localparam int          CODE_W      = 12;
  localparam int          CODE_MSB    = 11;
  localparam logic [11:0] CODE_ONES   = 12'hFFF;
  localparam logic [11:0] CODE_ZEROS  = 12'h000;
  localparam logic [11:0] BIPOLAR_MID = 12'h7FF;

  typedef enum logic [1:0] {
    RANGE_OVER_HIGH,
    RANGE_OVER_LOW,
    RANGE_IN
  } range_class_t;

  // one captured conversion as it travels through the buffer
  typedef struct packed {
    logic [11:0] code;         // offset binary or unipolar
    logic [11:0] code_twos;    // top bit taken from inverted pin
    logic        over_range;
    logic        over_high;
    logic        timeout;
  } sample_t;

  localparam int SAMPLE_W = $bits(sample_t);

endpackage : conv_host_pkg

// file: hw/sample_fifo.sv
// synchronous fifo for captured conversion results
// assumes one clock; width and depth shape the storage
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer arithmetic wraps at depth so non power of two depths work
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // data array has no reset; only valid entries are ever read out
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  a_fifo_bound: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : sample_fifo

// file: hw/conv_host.sv
// host controller that issues start strobes and captures results
// assumes converter pins arrive synchronous to clock_i; no software registers
module conv_host #(
  parameter int  DEPTH         = 16,
  parameter bit  SLOW_GRADE    = 1'b0,  // 0 fast grade, 1 slow grade
  parameter bit  CAPTURE_PREV  = 1'b0,  // capture on data-valid fall instead
  parameter int  TIMEOUT_CYC   = conv_host_pkg::DAV_TIMEOUT_CYC
) (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  // user side
  input  wire logic                          start_req_i,  // level: convert while high
  output logic                               busy_o,
  output logic                               settle_ok_o,  // third flash reached
  output conv_host_pkg::sample_t             sample_o,
  output logic                               sample_valid_o,
  input  wire logic                          sample_ready_i,
  output logic                               overflow_o,
  // converter pins
  output logic                               conversion_start_strobe_o,
  input  wire logic                          data_valid_strobe_i,
  input  wire logic                          over_range_flag_i,
  input  wire logic [11:0]                   data_i,
  input  wire logic                          msb_inv_i
);

  localparam int HIGH_CYC = SLOW_GRADE ? conv_host_pkg::SLOW_HIGH_CYC : conv_host_pkg::FAST_HIGH_CYC;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE,
    ST_WAIT_DAV,
    ST_WAIT_FALL
  } state_t;

  // ---------------------------------------------------------------------------
  // classification of a captured word
  // ---------------------------------------------------------------------------
  function automatic conv_host_pkg::range_class_t classify(input logic over_range_flag, input logic [11:0] code);
    if (!over_range_flag) begin
      classify = conv_host_pkg::RANGE_IN;
    end else if (code == conv_host_pkg::CODE_ONES) begin
      classify = conv_host_pkg::RANGE_OVER_HIGH;
    end else begin
      classify = conv_host_pkg::RANGE_OVER_LOW;
    end
  endfunction : classify

  // ---------------------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------------------
  state_t      state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  logic        strobe_q, strobe_d;
  logic        dav_q, dav_d;
  logic        settle_q, settle_d;
  logic        ovf_q, ovf_d;
  logic        cap_ev, dav_rise, dav_fall, timed_out;
  logic        fifo_ready;
  conv_host_pkg::sample_t       cap_word;
  conv_host_pkg::range_class_t  cls;

  assign dav_rise  = data_valid_strobe_i && !dav_q;
  assign dav_fall  = !data_valid_strobe_i && dav_q;
  assign timed_out = (state_q == ST_WAIT_DAV) && (cnt_q == 11'(TIMEOUT_CYC - 1));
  // capture edge chosen at build time; previous-data mode grabs on the fall
  assign cap_ev    = CAPTURE_PREV ? dav_fall : dav_rise;
  assign cls       = classify(over_range_flag_i, data_i);

  // assemble the word at capture time; twos complement uses inverted top pin
  always_comb begin
    cap_word            = '0;
    cap_word.code       = data_i;
    cap_word.code_twos  = {msb_inv_i, data_i[10:0]};
    cap_word.over_range = over_range_flag_i;
    cap_word.over_high  = (cls == conv_host_pkg::RANGE_OVER_HIGH);
    cap_word.timeout    = timed_out;
  end

  // next state; a new pulse only starts when the buffer has room
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    strobe_d = 1'b0;
    dav_d    = data_valid_strobe_i;
    settle_d = settle_q;
    ovf_d    = ovf_q;
    case (state_q)
      ST_IDLE: begin
        settle_d = 1'b0;
        // a start only once data-valid is low again, so no edge lands mid conversion
        if (start_req_i && fifo_ready && !data_valid_strobe_i) begin
          state_d  = ST_PULSE;
          cnt_d    = '0;
          strobe_d = 1'b1;
        end
      end
      ST_PULSE: begin
        // drop well inside the window so no edge lands in the final stages
        if (cnt_q == 11'(HIGH_CYC - 2)) begin
          state_d = ST_WAIT_DAV;
          cnt_d   = '0;
        end else begin
          strobe_d = 1'b1;
          cnt_d    = cnt_q + 11'd1;
        end
      end
      ST_WAIT_DAV: begin
        cnt_d = cnt_q + 11'd1;
        if (cnt_q == 11'(conv_host_pkg::SETTLE_CYC - HIGH_CYC)) begin
          settle_d = 1'b1;
        end
        if (dav_rise || timed_out) begin
          state_d = ST_WAIT_FALL;
        end
      end
      ST_WAIT_FALL: begin
        if (!data_valid_strobe_i) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (cap_ev && !fifo_ready) begin
      ovf_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      strobe_q <= 1'b0;
      dav_q    <= 1'b0;
      settle_q <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      strobe_q <= strobe_d;
      dav_q    <= dav_d;
      settle_q <= settle_d;
      ovf_q    <= ovf_d;
    end
  end

  assign conversion_start_strobe_o = strobe_q;
  assign busy_o                    = (state_q != ST_IDLE);
  assign settle_ok_o               = settle_q;
  assign overflow_o                = ovf_q;

  // ---------------------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------------------
  sample_fifo #(
    .WIDTH (conv_host_pkg::SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_data_i   (cap_word),
    .in_valid_i  (cap_ev || timed_out),
    .in_ready_o  (fifo_ready),
    .out_data_o  (sample_o),
    .out_valid_o (sample_valid_o),
    .out_ready_i (sample_ready_i)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [7:0] high_run_q, high_run_d;
  logic [7:0] since_q, since_d;

  // helper counters: strobe high run, and cycles since the sequencer left idle
  // the since counter saturates so a long timeout cannot wrap it into a false match
  always_comb begin
    high_run_d = strobe_q ? high_run_q + 8'h01 : 8'h00;
    since_d    = since_q;
    if (state_q == ST_IDLE) begin
      since_d = 8'h00;
    end else if (since_q != 8'hFF) begin
      since_d = since_q + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_run_q <= '0;
      since_q    <= '0;
    end else begin
      high_run_q <= high_run_d;
      since_q    <= since_d;
    end
  end

  a_strobe_width: assert property (@(posedge clock_i) disable iff (!rstn_i)
    high_run_q < 8'(HIGH_CYC)) else $error("start strobe high too long");
  a_strobe_pulse: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(strobe_q) |=> strobe_q) else $error("start strobe not a pulse");
  a_strobe_fall: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(strobe_q) |-> ##[1:12] !strobe_q) else $error("start strobe did not fall");
  a_no_restart: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (state_q == ST_WAIT_DAV) |-> !strobe_d) else $error("restart before data-valid");
  a_capture_push: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (cap_ev && fifo_ready) |=> sample_valid_o) else $error("capture lost");
  a_twos_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cap_word.code_twos[10:0] == cap_word.code[10:0]) else $error("twos code low bits differ");
  a_range_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cap_word.over_high |-> cap_word.over_range) else $error("over high without flag");
  a_settle_time: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(settle_q) |-> $past(state_q) == ST_WAIT_DAV) else $error("settle outside wait");
  a_settle_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(settle_q) |-> since_q == 8'(conv_host_pkg::SETTLE_CYC)) else $error("settle flag off its delay");

  c_conversion: cover property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(strobe_q) ##[1:300] dav_rise);
  c_over_range: cover property (@(posedge clock_i) disable iff (!rstn_i) cap_ev && over_range_flag_i);
  c_fifo_full:  cover property (@(posedge clock_i) disable iff (!rstn_i) !fifo_ready);
  c_timeout:    cover property (@(posedge clock_i) disable iff (!rstn_i) timed_out);
  c_settle:     cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(settle_q));

endmodule : conv_host

// file: verification/conv_model.sv
// behavioural converter that answers the host's start strobe
// assumes the strobe is synchronous to clock_i; step timing counted in clocks
module conv_model #(
  parameter int MAX_HIGH = conv_host_pkg::FAST_HIGH_CYC  // longest legal strobe run in clocks
) (
  input  wire logic        clock_i,
  input  wire logic        conversion_start_strobe_i,
  input  wire logic [11:0] level_i,     // in-range code the steps resolve
  input  wire logic [1:0]  range_i,     // range_class_t of the input
  input  wire logic [7:0]  conv_cyc_i,  // conversion time, at least 2
  input  wire logic        mute_i,      // ignore starts to provoke a timeout
  output logic             data_valid_strobe_o,
  output logic             over_range_flag_o,
  output logic [11:0]      data_o,
  output logic             msb_inv_o,
  output logic             strobe_err_o // host broke the strobe timing
);
  timeunit 1ns;
  timeprecision 100ps;

  int          cnt_q;  // conversion step counter, 0 when idle
  int          hi_q;   // strobe high time in clocks
  logic        st_q;
  logic [11:0] res;

  // forced codes out of range, else the merged four-step code
  always_comb begin
    if (range_i == conv_host_pkg::RANGE_OVER_HIGH) res = 12'hFFF;
    else if (range_i == conv_host_pkg::RANGE_OVER_LOW) res = 12'h000;
    // level_i stands for the ideally quantised input, transition offsets already applied
    else res = level_i;
  end

  initial begin
    cnt_q = 0;
    hi_q = 0;
    st_q = 1'b0;
    strobe_err_o = 1'b0;
    data_valid_strobe_o = 1'b0;
    over_range_flag_o = 1'b0;
    data_o = 12'hA5A;
    msb_inv_o = 1'b1;
  end

  // own sequencer: the strobe edge and mute_i are the only controls it obeys
  always @(posedge clock_i) begin
    st_q <= conversion_start_strobe_i;
    hi_q <= conversion_start_strobe_i ? hi_q + 1 : 0;
    if (conversion_start_strobe_i && hi_q >= MAX_HIGH) strobe_err_o <= 1'b1;
    if (conversion_start_strobe_i && !st_q && cnt_q != 0) strobe_err_o <= 1'b1;
    if (conversion_start_strobe_i && !st_q && !mute_i) cnt_q <= 1;
    else if (cnt_q != 0) cnt_q <= (cnt_q == conv_cyc_i + 3) ? 0 : cnt_q + 1;
    // latches load a cycle before data-valid so the host never sees stale bits
    if (cnt_q == conv_cyc_i - 1) begin
      data_o <= res;
      over_range_flag_o <= (range_i != conv_host_pkg::RANGE_IN);
      msb_inv_o <= ~res[11];
    end
    data_valid_strobe_o <= (cnt_q != 0) && (cnt_q >= conv_cyc_i);
  end
endmodule : conv_model

// file: verification/tb_top.sv
// self-checking bench for the conversion host and its result buffer
// assumes conv_model stands in for the converter on the pins
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   clock_i, rstn_i, start_req_i, sample_ready_i;
  logic                   busy_o, settle_ok_o, sample_valid_o, overflow_o;
  logic                   strobe, data_valid_strobe, over_range_flag, msb_inv, mute, serr;
  logic [11:0]            data, level;
  logic [1:0]             range;
  logic [7:0]             conv_cyc;
  conv_host_pkg::sample_t sample_o;
  conv_host_pkg::sample_t s;
  int                     n_fail, checks_done, w;
  logic                   st;
  logic                   start_s, ready_s, busy_s, settle_s, valid_s, ovf_s;
  logic                   strobe_s, dav_s, otr_s, msbi_s, serr_s;
  logic [11:0]            data_s;
  conv_host_pkg::sample_t sample_s;

  // short timeout keeps the stalled-converter case quick
  conv_host #(.TIMEOUT_CYC(96)) u_conv_host (.clock_i(clock_i), .rstn_i(rstn_i),
    .start_req_i(start_req_i), .busy_o(busy_o), .settle_ok_o(settle_ok_o), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i), .overflow_o(overflow_o),
    .conversion_start_strobe_o(strobe), .data_valid_strobe_i(data_valid_strobe), .over_range_flag_i(over_range_flag),
    .data_i(data), .msb_inv_i(msb_inv));
  conv_model u_conv_model (.clock_i(clock_i), .conversion_start_strobe_i(strobe), .level_i(level),
    .range_i(range), .conv_cyc_i(conv_cyc), .mute_i(mute), .data_valid_strobe_o(data_valid_strobe),
    .over_range_flag_o(over_range_flag), .data_o(data), .msb_inv_o(msb_inv), .strobe_err_o(serr));

  // slow grade with capture on the data-valid fall, beside the fast one
  conv_host #(.SLOW_GRADE(1'b1), .CAPTURE_PREV(1'b1), .TIMEOUT_CYC(96)) u_conv_host_slow (.clock_i(clock_i),
    .rstn_i(rstn_i), .start_req_i(start_s), .busy_o(busy_s), .settle_ok_o(settle_s), .sample_o(sample_s),
    .sample_valid_o(valid_s), .sample_ready_i(ready_s), .overflow_o(ovf_s),
    .conversion_start_strobe_o(strobe_s), .data_valid_strobe_i(dav_s), .over_range_flag_i(otr_s),
    .data_i(data_s), .msb_inv_i(msbi_s));
  conv_model #(.MAX_HIGH(conv_host_pkg::SLOW_HIGH_CYC)) u_conv_model_slow (.clock_i(clock_i),
    .conversion_start_strobe_i(strobe_s), .level_i(level), .range_i(range), .conv_cyc_i(conv_cyc),
    .mute_i(1'b0), .data_valid_strobe_o(dav_s), .over_range_flag_o(otr_s), .data_o(data_s),
    .msb_inv_o(msbi_s), .strobe_err_o(serr_s));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: code %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic complete_run;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // bounded wait for the buffer head, then pop it
  task automatic get_sample(output conv_host_pkg::sample_t r, output logic so);
    int n;
    n = 0;
    while (sample_valid_o !== 1'b1 && n < 300) begin
      @(posedge clock_i); #1;
      n++;
    end
    chk_bit(sample_valid_o, 1'b1);
    r = sample_o;
    so = settle_ok_o;
    sample_ready_i = 1'b1;
    @(posedge clock_i); #1;
    sample_ready_i = 1'b0;
  endtask : get_sample

  // one request: measure the strobe width, fetch the word, wait for idle
  task automatic conv(output conv_host_pkg::sample_t r, output int wd, output logic so);
    int n;
    start_req_i = 1'b1;
    n = 0;
    while (strobe !== 1'b1 && n < 20) begin
      @(posedge clock_i); #1;
      n++;
    end
    start_req_i = 1'b0;
    wd = 0;
    while (strobe === 1'b1 && wd < 30) begin
      @(posedge clock_i); #1;
      wd++;
    end
    get_sample(r, so);
    n = 0;
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge clock_i); #1;
      n++;
    end
    chk_bit(busy_o, 1'b0);
  endtask : conv

  // short and long conversions across the bipolar midpoint
  task automatic t_basic;
    for (int i = 0; i < 2; i++) begin
      level = i ? 12'h800 : 12'h7FF;
      conv_cyc = i ? 8'h38 : 8'h14;
      conv(s, w, st);
      chk_bit(w == conv_host_pkg::FAST_HIGH_CYC - 1, 1'b1);
      chk_code(s.code, level);
      chk_code(s.code_twos, level ^ 12'h800);
      chk_bit(s.over_range, 1'b0);
      chk_bit(s.timeout, 1'b0);
      chk_bit(st, i ? 1'b1 : 1'b0);
    end
  endtask : t_basic

  // every range class: forced codes and the over-range flag
  task automatic t_range;
    level = 12'h123;
    conv_cyc = 8'h14;
    for (int r = 0; r < 3; r++) begin
      range = r[1:0];
      conv(s, w, st);
      chk_code(s.code, r == 0 ? 12'hFFF : r == 1 ? 12'h000 : 12'h123);
      chk_bit(s.over_range, r != 2);
      chk_bit(s.over_high, r == 0);
    end
  endtask : t_range

  // converter never answers: the host must give up with a marked word
  task automatic t_timeout;
    mute = 1'b1;
    conv(s, w, st);
    chk_bit(s.timeout, 1'b1);
    mute = 1'b0;
  endtask : t_timeout

  // back-to-back starts until the buffer refuses, then drain it
  task automatic t_fill;
    level = 12'h5C3;
    start_req_i = 1'b1;
    repeat (900) @(posedge clock_i);
    #1;
    chk_bit(busy_o, 1'b0);
    chk_bit(strobe, 1'b0);
    chk_bit(overflow_o, 1'b0);
    start_req_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      get_sample(s, st);
      chk_code(s.code, level);
    end
    chk_bit(sample_valid_o, 1'b0);
    chk_bit(serr, 1'b0);
  endtask : t_fill

  // slow grade, capture on the data-valid fall: the word may only appear after the fall
  task automatic t_slow;
    int n;
    level = 12'h3A7;
    conv_cyc = 8'h38;
    start_s = 1'b1;
    n = 0;
    while (strobe_s !== 1'b1 && n < 20) begin
      @(posedge clock_i); #1;
      n++;
    end
    start_s = 1'b0;
    n = 0;
    while (strobe_s === 1'b1 && n < 30) begin
      @(posedge clock_i); #1;
      n++;
    end
    chk_bit(n == conv_host_pkg::SLOW_HIGH_CYC - 1, 1'b1);
    n = 0;
    while (valid_s !== 1'b1 && n < 300) begin
      @(posedge clock_i); #1;
      n++;
    end
    chk_bit(valid_s, 1'b1);
    chk_bit(dav_s, 1'b0);
    chk_code(sample_s.code, level);
    chk_code(sample_s.code_twos, level ^ 12'h800);
    chk_bit(settle_s, 1'b1);
    chk_bit(busy_s, 1'b0);
    ready_s = 1'b1;
    @(posedge clock_i); #1;
    ready_s = 1'b0;
    chk_bit(valid_s, 1'b0);
    chk_bit(ovf_s, 1'b0);
    chk_bit(serr_s, 1'b0);
  endtask : t_slow

  initial begin
    n_fail = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    start_s = 1'b0;
    ready_s = 1'b0;
    start_req_i = 1'b0;
    sample_ready_i = 1'b0;
    mute = 1'b0;
    level = 12'h000;
    range = conv_host_pkg::RANGE_IN;
    conv_cyc = 8'h14;
    repeat (3) @(posedge clock_i);
    #1;
    chk_bit(strobe, 1'b0);
    chk_bit(sample_valid_o, 1'b0);
    rstn_i = 1'b1;
    t_basic();
    t_range();
    t_timeout();
    t_fill();
    t_slow();
    complete_run();
  end

  // watchdog: the whole run needs well under 3000 clocks
  initial begin
    #(8000 * 4);
    n_fail++;
    complete_run();
  end
endmodule : tb_top
